// >>> pkg/virq_pkg.sv
// Constants, offsets and field layouts of the vectored interrupt register bank.
package virq_pkg;
   // Build shape of this instance.
   localparam int          NUM_IRQ       = 32;
   localparam logic        CHAIN_PRESENT = 1'b1;
   localparam logic [31:0] BUILT_MASK    = 32'((64'h1 << NUM_IRQ) - 64'h1);

   // Widths.
   localparam int ADDR_W  = 6;
   localparam int DATA_W  = 32;
   localparam int LVL_W   = 6;
   localparam int RS_W    = 6;
   localparam int CFG_W   = 13;
   localparam int IDX_W   = 6;
   localparam int VSIZE_W = 3;
   localparam int CHAIN_W = 45;

   // Field positions.
   localparam int LVL_LSB     = 0;
   localparam int NMI_BIT     = 6;
   localparam int RS_LSB      = 7;
   localparam int VSIZE_LSB   = 0;
   localparam int CHAINEN_BIT = 3;
   localparam int PEND_BIT    = 31;
   localparam int CHAIN_HA_LSB = 13;

   // Word offsets on the register port.
   localparam logic [ADDR_W-1:0] OFF_CFG_LAST   = 6'h1f;
   localparam logic [ADDR_W-1:0] OFF_ENABLE     = 6'h20;
   localparam logic [ADDR_W-1:0] OFF_ENABLE_SET = 6'h21;
   localparam logic [ADDR_W-1:0] OFF_ENABLE_CLR = 6'h22;
   localparam logic [ADDR_W-1:0] OFF_PENDING    = 6'h23;
   localparam logic [ADDR_W-1:0] OFF_RAW        = 6'h24;
   localparam logic [ADDR_W-1:0] OFF_SOFT       = 6'h25;
   localparam logic [ADDR_W-1:0] OFF_SOFT_SET   = 6'h26;
   localparam logic [ADDR_W-1:0] OFF_SOFT_CLR   = 6'h27;
   localparam logic [ADDR_W-1:0] OFF_CONFIG     = 6'h28;
   localparam logic [ADDR_W-1:0] OFF_STATE      = 6'h29;
   localparam logic [ADDR_W-1:0] OFF_TBL_BASE   = 6'h2a;
   localparam logic [ADDR_W-1:0] OFF_HANDLER    = 6'h2b;

   // Values and counts.
   localparam logic [DATA_W-1:0] RESET_WORD = 32'h0;
   localparam logic [IDX_W-1:0]  CHAIN_IDX  = 6'h20;
   localparam logic [3:0]        ENTRY_LOG2 = 4'h2;
endpackage

// >>> logic/virq_priority_pick.sv
// Winner selection among pending interrupts and the chained input.
`timescale 1ns/1ps
module virq_priority_pick
(
   input  wire logic [31:0]                                  pending,
   input  wire logic [virq_pkg::NUM_IRQ*virq_pkg::LVL_W-1:0] levels,
   input  wire logic                                         chainOn,
   input  wire logic [virq_pkg::LVL_W-1:0]                   chainLevel,
   input  wire logic                                         clock,
   input  wire logic                                         rst,
   output logic                                              found,
   output logic [virq_pkg::IDX_W-1:0]                        winIdx,
   output logic [virq_pkg::LVL_W-1:0]                        winLevel,
   output logic                                              chainWon
);
   import virq_pkg::*;

   logic [NUM_IRQ-1:0] beaten;

   // Scan from the top index down so an equal level at a lower index takes over.
   always_comb begin
      found    = 1'b0;
      winIdx   = '0;
      winLevel = '0;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (pending[i] && levels[i*LVL_W +: LVL_W] != '0 &&
             levels[i*LVL_W +: LVL_W] >= winLevel) begin
            found    = 1'b1;
            winIdx   = IDX_W'(i);
            winLevel = levels[i*LVL_W +: LVL_W];
         end
      end
   end

   // The chain acts as index 32, so it only wins with a strictly larger level.
   assign chainWon = chainOn && chainLevel != '0 && chainLevel > winLevel;

   // A pending input that should have beaten the chosen winner.
   for (genvar g = 0; g < NUM_IRQ; g++) begin : g_beat
      assign beaten[g] = pending[g] && levels[g*LVL_W +: LVL_W] != '0 &&
         (levels[g*LVL_W +: LVL_W] > winLevel ||
          (levels[g*LVL_W +: LVL_W] == winLevel && IDX_W'(g) < winIdx));
   end

   chk_pick_order:
   assert property (@(posedge clock) disable iff (rst) beaten == '0)
      else $error("A better pending interrupt was passed over.");
endmodule

// >>> logic/virq_vector_gen.sv
// Handler address arithmetic for the winning interrupt.
`timescale 1ns/1ps
module virq_vector_gen
(
   input  wire logic [virq_pkg::IDX_W-1:0]   winIdx,
   input  wire logic [virq_pkg::VSIZE_W-1:0] vecSize,
   input  wire logic [31:0]                  tableBase,
   input  wire logic                         chainWon,
   input  wire logic [31:0]                  chainAddr,
   output logic [31:0]                       handler
);
   import virq_pkg::*;

   logic [3:0]  entryShift;
   logic [31:0] entryOffset;

   // Bytes per entry are four shifted by the size field, so index times bytes is a shift.
   assign entryShift  = {1'b0, vecSize} + ENTRY_LOG2;
   assign entryOffset = {26'h0, winIdx} << entryShift;
   assign handler     = chainWon ? chainAddr : tableBase + entryOffset;
endmodule

// >>> logic/virq_csr_bank.sv
// Register bank, request gating and winner status of the vectored interrupt controller.
`timescale 1ns/1ps
module virq_csr_bank
(
   input  wire logic                         clock,
   input  wire logic                         rst,
   input  wire logic                         csrRead,
   input  wire logic                         csrWrite,
   input  wire logic [virq_pkg::ADDR_W-1:0]  csrAddress,
   input  wire logic [virq_pkg::DATA_W-1:0]  csrWriteData,
   output logic [virq_pkg::DATA_W-1:0]       csrReadData,
   input  wire logic [31:0]                  irqInput,
   input  wire logic                         chainValid,
   input  wire logic [virq_pkg::CHAIN_W-1:0] chainData,
   output logic                              reqValid,
   output logic [virq_pkg::LVL_W-1:0]        reqLevel,
   output logic                              reqNonmask,
   output logic [virq_pkg::RS_W-1:0]         reqRegSet,
   output logic [31:0]                       reqHandler
);
   import virq_pkg::*;

   // Software state.
   logic [CFG_W-1:0]   cfgTable [0:31];
   logic [31:0]        irqEnableMask;
   logic [31:0]        softIrqBits;
   logic [VSIZE_W-1:0] vecSize;
   logic               chainEnable;
   logic [31:0]        handlerTableBase;

   // Registered winner status.
   logic               winValid;
   logic [IDX_W-1:0]   winNumber;
   logic [31:0]        handlerAddr;

   // Decode, next values and datapath wires.
   logic               wrCfg;
   logic               wrEnable;
   logic               wrEnSet;
   logic               wrEnClr;
   logic               wrSoft;
   logic               wrSoftSet;
   logic               wrSoftClr;
   logic               wrConfig;
   logic               wrTblBase;
   logic [31:0]        next_irqEnableMask;
   logic [31:0]        next_softIrqBits;
   logic [31:0]        pendingFlags;
   logic [31:0]        rawInputs;
   logic [NUM_IRQ*LVL_W-1:0] levelsFlat;
   logic               chainOn;
   logic               found;
   logic               chainWon;
   logic               anyWin;
   logic [IDX_W-1:0]   pickIdx;
   logic [31:0]        handler;
   logic [CFG_W-1:0]   winCfg;
   logic [31:0]        cfgWord;
   logic [31:0]        configWord;
   logic [31:0]        stateWord;
   logic [31:0]        readMux;

   // Write strobes; a write takes effect at the edge where csrWrite is high.
   assign wrCfg     = csrWrite && csrAddress <= OFF_CFG_LAST;
   assign wrEnable  = csrWrite && csrAddress == OFF_ENABLE;
   assign wrEnSet   = csrWrite && csrAddress == OFF_ENABLE_SET;
   assign wrEnClr   = csrWrite && csrAddress == OFF_ENABLE_CLR;
   assign wrSoft    = csrWrite && csrAddress == OFF_SOFT;
   assign wrSoftSet = csrWrite && csrAddress == OFF_SOFT_SET;
   assign wrSoftClr = csrWrite && csrAddress == OFF_SOFT_CLR;
   assign wrConfig  = csrWrite && csrAddress == OFF_CONFIG;
   assign wrTblBase = csrWrite && csrAddress == OFF_TBL_BASE;

   // Set and clear aliases act only on the ones of the written word.
   assign next_irqEnableMask = wrEnable ? csrWriteData & BUILT_MASK :
                               wrEnSet  ? irqEnableMask | (csrWriteData & BUILT_MASK) :
                               wrEnClr  ? irqEnableMask & ~csrWriteData :
                                          irqEnableMask;
   assign next_softIrqBits   = wrSoft    ? csrWriteData & BUILT_MASK :
                               wrSoftSet ? softIrqBits | (csrWriteData & BUILT_MASK) :
                               wrSoftClr ? softIrqBits & ~csrWriteData :
                                           softIrqBits;

   // Per-interrupt configuration words, request gating and level fan-out.
   for (genvar g = 0; g < 32; g++) begin : g_irq
      if (g < NUM_IRQ) begin : g_built
         // Only the 13 defined bits are stored, so reserved bits cannot hold data.
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               cfgTable[g] <= '0;
            end else if (wrCfg && csrAddress[4:0] == 5'(g)) begin
               cfgTable[g] <= csrWriteData[CFG_W-1:0];
            end
         end
         assign levelsFlat[g*LVL_W +: LVL_W] = cfgTable[g][LVL_LSB +: LVL_W];
      end else begin : g_absent
         assign cfgTable[g] = '0;
      end
      // Soft bit joins the input before the enable gate.
      assign pendingFlags[g] = BUILT_MASK[g] && irqEnableMask[g] &&
                               (irqInput[g] || softIrqBits[g]);
      assign rawInputs[g]    = BUILT_MASK[g] && irqInput[g];
   end

   // Enable mask and soft bits.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqEnableMask <= '0;
         softIrqBits   <= '0;
      end else begin
         irqEnableMask <= next_irqEnableMask;
         softIrqBits   <= next_softIrqBits;
      end
   end

   // The chain enable bit sticks only when the chained input exists, which is
   // how software probes for it.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         vecSize          <= '0;
         chainEnable      <= 1'b0;
         handlerTableBase <= '0;
      end else begin
         if (wrConfig) begin
            vecSize     <= csrWriteData[VSIZE_LSB +: VSIZE_W];
            chainEnable <= csrWriteData[CHAINEN_BIT] && CHAIN_PRESENT;
         end
         if (wrTblBase) begin
            handlerTableBase <= csrWriteData;
         end
      end
   end

   // Priority and vector generation.
   assign chainOn = CHAIN_PRESENT && chainEnable && chainValid;

   virq_priority_pick u_pick (
      .pending    (pendingFlags),
      .levels     (levelsFlat),
      .chainOn    (chainOn),
      .chainLevel (chainData[LVL_LSB +: LVL_W]),
      .clock      (clock),
      .rst        (rst),
      .found      (found),
      .winIdx     (pickIdx),
      .winLevel   (),
      .chainWon   (chainWon)
   );

   virq_vector_gen u_vec (
      .winIdx    (pickIdx),
      .vecSize   (vecSize),
      .tableBase (handlerTableBase),
      .chainWon  (chainWon),
      .chainAddr (chainData[CHAIN_HA_LSB +: 32]),
      .handler   (handler)
   );

   assign anyWin = found || chainWon;
   assign winCfg = chainWon ? chainData[CFG_W-1:0] : cfgTable[pickIdx[4:0]];

   // Winner status and the request toward the processor are sampled once per
   // cycle, which costs one cycle of latency but keeps every output a flip-flop.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         winValid    <= 1'b0;
         winNumber   <= '0;
         handlerAddr <= '0;
      end else begin
         winValid    <= anyWin;
         winNumber   <= chainWon ? CHAIN_IDX : (found ? pickIdx : '0);
         handlerAddr <= anyWin ? handler : '0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reqValid   <= 1'b0;
         reqLevel   <= '0;
         reqNonmask <= 1'b0;
         reqRegSet  <= '0;
         reqHandler <= '0;
      end else begin
         reqValid   <= anyWin;
         reqLevel   <= anyWin ? winCfg[LVL_LSB +: LVL_W] : '0;
         reqNonmask <= anyWin && winCfg[NMI_BIT];
         reqRegSet  <= anyWin ? winCfg[RS_LSB +: RS_W] : '0;
         reqHandler <= anyWin ? handler : '0;
      end
   end

   // Read selection; aliases and unmapped words read as zero.
   assign cfgWord    = {19'h0, cfgTable[csrAddress[4:0]]};
   assign configWord = {28'h0, chainEnable, vecSize};
   assign stateWord  = {winValid, 25'h0, winNumber};
   assign readMux    = csrAddress <= OFF_CFG_LAST     ? cfgWord :
                       csrAddress == OFF_ENABLE       ? irqEnableMask :
                       csrAddress == OFF_PENDING      ? pendingFlags :
                       csrAddress == OFF_RAW          ? rawInputs :
                       csrAddress == OFF_SOFT         ? softIrqBits :
                       csrAddress == OFF_CONFIG       ? configWord :
                       csrAddress == OFF_STATE        ? stateWord :
                       csrAddress == OFF_TBL_BASE     ? handlerTableBase :
                       csrAddress == OFF_HANDLER      ? handlerAddr :
                                                        RESET_WORD;

   // One wait state on reads: the word is captured at the edge that takes the read.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         csrReadData <= '0;
      end else if (csrRead) begin
         csrReadData <= readMux;
      end
   end

   chk_enset_bits:
   assert property (@(posedge clock) disable iff (rst)
      csrWrite && csrAddress == OFF_ENABLE_SET |=>
      irqEnableMask == ($past(irqEnableMask) | ($past(csrWriteData) & BUILT_MASK)))
      else $error("Enable setter did not set exactly the written ones.");

   chk_enclr_bits:
   assert property (@(posedge clock) disable iff (rst)
      csrWrite && csrAddress == OFF_ENABLE_CLR |=>
      irqEnableMask == ($past(irqEnableMask) & ~$past(csrWriteData)))
      else $error("Enable clearer did not clear exactly the written ones.");

   chk_softset_bits:
   assert property (@(posedge clock) disable iff (rst)
      csrWrite && csrAddress == OFF_SOFT_SET |=>
      softIrqBits == ($past(softIrqBits) | ($past(csrWriteData) & BUILT_MASK)))
      else $error("Soft setter did not set exactly the written ones.");

   chk_softclr_bits:
   assert property (@(posedge clock) disable iff (rst)
      csrWrite && csrAddress == OFF_SOFT_CLR |=>
      softIrqBits == ($past(softIrqBits) & ~$past(csrWriteData)))
      else $error("Soft clearer did not clear exactly the written ones.");

   chk_alias_reads:
   assert property (@(posedge clock) disable iff (rst)
      csrRead && (csrAddress == OFF_ENABLE_SET || csrAddress == OFF_SOFT_CLR) |=>
      csrReadData == RESET_WORD)
      else $error("A write-only alias read back nonzero.");

   chk_pending_gate:
   assert property (@(posedge clock) disable iff (rst)
      (pendingFlags & ~irqEnableMask) == 32'h0 &&
      ((irqInput | softIrqBits) & irqEnableMask & BUILT_MASK) == pendingFlags)
      else $error("Pending flags disagree with enables and requests.");

   chk_idle_handler:
   assert property (@(posedge clock) disable iff (rst)
      !winValid |-> handlerAddr == 32'h0 && winNumber == '0)
      else $error("Idle state shows a nonzero handler or number.");

   chk_handler_math:
   assert property (@(posedge clock) disable iff (rst)
      winValid && winNumber != CHAIN_IDX |->
      handlerAddr == $past(handlerTableBase) +
                     ({26'h0, winNumber} << ({1'b0, $past(vecSize)} + ENTRY_LOG2)))
      else $error("Handler address is not base plus index times entry size.");

   chk_state_follow:
   assert property (@(posedge clock) disable iff (rst)
      $rose(anyWin) |=> winValid && stateWord[PEND_BIT])
      else $error("Pending flag did not follow a new winner.");

   chk_chain_pass:
   assert property (@(posedge clock) disable iff (rst)
      chainWon |=> winNumber == CHAIN_IDX &&
                   handlerAddr == $past(chainData[CHAIN_HA_LSB +: 32]))
      else $error("Chained winner did not pass its handler address.");

   // Read port, configuration write, request and winner gating checks; software polls these words, so a slip here is silent.
   chk_read_hold:
   assert property (@(posedge clock) disable iff (rst)
      !csrRead |=> $stable(csrReadData))
      else $error("Read data moved without a read.");

   chk_raw_read:
   assert property (@(posedge clock) disable iff (rst)
      csrRead && csrAddress == OFF_RAW |=>
      csrReadData == ($past(irqInput) & BUILT_MASK))
      else $error("Raw input read did not show the input levels.");

   chk_cfg_write:
   assert property (@(posedge clock) disable iff (rst)
      wrCfg |=> cfgTable[$past(csrAddress[4:0])] == $past(csrWriteData[CFG_W-1:0]))
      else $error("Configuration word did not keep its defined bits.");

   chk_req_idle:
   assert property (@(posedge clock) disable iff (rst)
      !reqValid |-> reqLevel == '0 && !reqNonmask && reqRegSet == '0 && reqHandler == 32'h0)
      else $error("Idle request outputs are not all zero.");

   chk_win_enabled:
   assert property (@(posedge clock) disable iff (rst)
      found |-> irqEnableMask[pickIdx[4:0]] && pendingFlags[pickIdx[4:0]])
      else $error("A disabled or idle interrupt won priority.");

   chk_chain_gate:
   assert property (@(posedge clock) disable iff (rst)
      chainWon |-> chainEnable && chainValid && chainData[LVL_LSB +: LVL_W] != '0)
      else $error("Chained input won while disabled or at level zero.");
endmodule

// >>> test/virq_master.sv
// Processor data master model that issues single-word register reads and writes.
`timescale 1ns/1ps
module virq_master
(
   input  wire logic                        clock,
   output logic                             csrRead,
   output logic                             csrWrite,
   output logic [virq_pkg::ADDR_W-1:0]      csrAddress,
   output logic [virq_pkg::DATA_W-1:0]      csrWriteData,
   input  wire logic [virq_pkg::DATA_W-1:0] csrReadData
);
   import virq_pkg::*;

   // Idle bus at time zero.
   initial begin
      csrRead = 1'b0;
      csrWrite = 1'b0;
      csrAddress = '0;
      csrWriteData = '0;
   end

   // Released lines show the inverse of their last value so stale data is never mistaken.
   task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] w;
      w = (a == OFF_TBL_BASE) ? {d[31:2], 2'b00} : d;
      @(posedge clock);
      #1;
      csrWrite = 1'b1;
      csrAddress = a;
      csrWriteData = w;
      @(posedge clock);
      #1;
      csrWrite = 1'b0;
      csrAddress = ~a;
      csrWriteData = ~w;
   endtask

   // Read data is taken one settle delay after the edge that took the request.
   task automatic read_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clock);
      #1;
      csrRead = 1'b1;
      csrAddress = a;
      @(posedge clock);
      #1;
      d = csrReadData;
      csrRead = 1'b0;
      csrAddress = ~a;
   endtask
endmodule

// >>> test/test_vectored_irq_csr_bank.sv
// Self-checking bench for the vectored interrupt register bank.
`timescale 1ns/1ps
module test_vectored_irq_csr_bank;
   import virq_pkg::*;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wr;
      logic [DATA_W-1:0] exp;
   } virq_row_t;

   logic               clock = 1'b0;
   logic               rst;
   logic               csrRead;
   logic               csrWrite;
   logic [ADDR_W-1:0]  csrAddress;
   logic [DATA_W-1:0]  csrWriteData;
   logic [DATA_W-1:0]  csrReadData;
   logic [31:0]        irqInput;
   logic               chainValid;
   logic [CHAIN_W-1:0] chainData;
   logic               reqValid;
   logic [LVL_W-1:0]   reqLevel;
   logic               reqNonmask;
   logic [RS_W-1:0]    reqRegSet;
   logic [31:0]        reqHandler;
   int                 errors = 0;
   int                 n_compared = 0;
   int                 cycles = 0;

   // Write a word, read it back: reserved, read-only and alias places must not keep it.
   // The soft word is filled whole and then emptied by its clearer before any status read.
   virq_row_t rows [15] = '{
      '{6'h00, 32'hffffffff, 32'h00001fff}, '{6'h1f, 32'h00001234, 32'h00001234},
      '{6'h20, 32'hffffffff, 32'hffffffff}, '{6'h21, 32'hffffffff, 32'h00000000},
      '{6'h22, 32'h00000000, 32'h00000000}, '{6'h23, 32'hffffffff, 32'h00000000},
      '{6'h24, 32'hffffffff, 32'h00000000}, '{6'h25, 32'hffffffff, 32'hffffffff},
      '{6'h26, 32'h00000000, 32'h00000000}, '{6'h27, 32'hffffffff, 32'h00000000},
      '{6'h28, 32'hffffffff, 32'h0000000f}, '{6'h29, 32'hffffffff, 32'h00000000},
      '{6'h2a, 32'h12345670, 32'h12345670}, '{6'h2b, 32'hffffffff, 32'h00000000},
      '{6'h3f, 32'hffffffff, 32'h00000000}};

   // Clock of 25 ns period.
   always #12.5 clock = ~clock;

   virq_master host (.clock(clock), .csrRead(csrRead), .csrWrite(csrWrite),
      .csrAddress(csrAddress), .csrWriteData(csrWriteData), .csrReadData(csrReadData));

   virq_csr_bank dut (.clock(clock), .rst(rst), .csrRead(csrRead), .csrWrite(csrWrite),
      .csrAddress(csrAddress), .csrWriteData(csrWriteData), .csrReadData(csrReadData),
      .irqInput(irqInput), .chainValid(chainValid), .chainData(chainData),
      .reqValid(reqValid), .reqLevel(reqLevel), .reqNonmask(reqNonmask),
      .reqRegSet(reqRegSet), .reqHandler(reqHandler));

   task automatic end_sim();
      $display("compared %0d values, %0d wrong", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Winner outputs compared as one word: valid, level, nmi, register set, handler.
   task automatic check_req(input logic [45:0] exp);
      n_compared++;
      if ({reqValid, reqLevel, reqNonmask, reqRegSet, reqHandler} !== exp) begin
         errors++;
         $display("wrong value at %0t: winner outputs expected %h", $time, exp);
      end
   endtask

   task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      host.read_word(a, d);
      check_word(d, exp, what);
   endtask

   // A hang ends the run well past the few hundred cycles the tests need.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         $display("wrong value at %0t: run did not finish", $time);
         end_sim();
      end
   end

   initial begin
      rst = 1'b1;
      irqInput = '0;
      chainValid = 1'b0;
      chainData = '0;
      repeat (2) @(posedge clock);
      #1 rst = 1'b0;
      for (int a = 0; a < 44; a++) rd_check(6'(a), 32'h0, "reset value");
      check_req(46'h0);
      $display("reset values done");
      foreach (rows[i]) begin
         host.write_word(rows[i].addr, rows[i].wr);
         rd_check(rows[i].addr, rows[i].exp, "register row");
      end
      $display("register rows done");
      host.write_word(OFF_ENABLE, 32'h0);
      host.write_word(OFF_ENABLE_SET, 32'h000000a5);
      host.write_word(OFF_ENABLE_SET, 32'h00000100);
      host.write_word(OFF_ENABLE_CLR, 32'h00000005);
      rd_check(OFF_ENABLE, 32'h000001a0, "enable set clear");
      host.write_word(OFF_SOFT_SET, 32'h00000003);
      host.write_word(OFF_SOFT_CLR, 32'h00000001);
      rd_check(OFF_SOFT, 32'h00000002, "soft set clear");
      irqInput = 32'h80000121;
      rd_check(OFF_RAW, 32'h80000121, "raw inputs");
      rd_check(OFF_PENDING, 32'h00000120, "masked pending");
      host.write_word(OFF_ENABLE_SET, 32'h00000002);
      rd_check(OFF_PENDING, 32'h00000122, "soft pending");
      $display("mask and pending done");
      // Equal levels on inputs 5 and 8; the lower index must win.
      host.write_word(6'h05, 32'h00000143);
      host.write_word(6'h08, 32'h00000283);
      host.write_word(OFF_CONFIG, 32'h00000002);
      host.write_word(OFF_TBL_BASE, 32'h00001000);
      rd_check(OFF_STATE, 32'h80000005, "tie lowest index");
      rd_check(OFF_HANDLER, 32'h00001050, "handler of tie");
      check_req({1'b1, 6'h03, 1'b1, 6'h02, 32'h00001050});
      host.write_word(6'h08, 32'h00000284);
      for (int s = 0; s < 8; s++) begin
         host.write_word(OFF_CONFIG, 32'(s));
         rd_check(OFF_HANDLER, 32'h00001000 + (32'h8 << (2 + s)), "vector size");
      end
      check_req({1'b1, 6'h04, 1'b0, 6'h05, 32'h00001000 + (32'h8 << 9)});
      $display("priority and vectors done");
      chainData = {32'habcd0000, 6'h03, 1'b0, 6'h05};
      chainValid = 1'b1;
      rd_check(OFF_STATE, 32'h80000008, "chain disabled");
      host.write_word(OFF_CONFIG, 32'h00000008);
      rd_check(OFF_STATE, 32'h80000020, "chain wins");
      rd_check(OFF_HANDLER, 32'habcd0000, "chain handler");
      check_req({1'b1, 6'h05, 1'b0, 6'h03, 32'habcd0000});
      chainData[5:0] = 6'h04;
      rd_check(OFF_STATE, 32'h80000008, "chain tie loses");
      chainValid = 1'b0;
      host.write_word(OFF_ENABLE_CLR, 32'h00000100);
      rd_check(OFF_STATE, 32'h80000005, "disabled input skipped");
      host.write_word(6'h05, 32'h00000140);
      rd_check(OFF_STATE, 32'h00000000, "level zero idle");
      rd_check(OFF_HANDLER, 32'h00000000, "idle handler");
      check_req(46'h0);
      $display("chain and gating done");
      rst = 1'b1;
      @(posedge clock);
      #1 rst = 1'b0;
      rd_check(OFF_ENABLE, 32'h0, "second reset");
      check_req(46'h0);
      $display("second reset done");
      end_sim();
   end
endmodule
